// File: core/dmaie_channel.sv
// Interrupt enables, flags and size-error stop for one transfer channel.
`timescale 1ns/1ps
`default_nettype none
`include "dmaie_regs.svh"

module dmaie_channel #(
  parameter int COUNT_W = 16
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire dmaie_pkg::dmaie_ctrl_wr_s ctrl_wr,
  input  wire logic                    xfer_request,
  input  wire logic                    last_xfer_done,
  input  wire logic                    escape_event,
  input  wire logic [COUNT_W-1:0]      transfer_count,
  input  wire logic [COUNT_W-1:0]      block_size,
  output dmaie_pkg::dmaie_ctrl_rd_s    ctrl_rd,
  output logic                         size_error,
  output logic                         escape_int_req,
  output logic                         count_end_int_req
);

  logic        channel_enable;
  logic        escape_int_flag;
  logic        count_end_int_flag;
  logic [1:0]  access_size;
  logic [1:0]  xfer_mode;
  logic        size_error_int_enable;
  logic        escape_int_enable;
  logic        count_end_int_enable;
  logic        too_small;
  logic        size_err_hit;
  logic        next_escape_flag;
  logic        next_count_end_flag;
  logic        next_channel_enable;
  logic [1:0]  next_access_size;
  logic [1:0]  next_xfer_mode;
  logic        next_size_error_int_enable;
  logic        next_escape_int_enable;
  logic        next_count_end_int_enable;

  dmaie_size_check #(
    .COUNT_W (COUNT_W)
  ) u_size_check (
    .access_size    (access_size),
    .xfer_mode      (xfer_mode),
    .transfer_count (transfer_count),
    .block_size     (block_size),
    .too_small      (too_small)
  );

  // A size error only counts on a live request with the enable set.
  assign size_err_hit = xfer_request && channel_enable && size_error_int_enable
                        && too_small;

  // Next configuration; prohibited codes are refused and the old value kept.
  // Readback and requests use these values so they never lag the registers.
  always_comb begin
    next_access_size           = access_size;
    next_xfer_mode             = xfer_mode;
    next_size_error_int_enable = size_error_int_enable;
    next_escape_int_enable     = escape_int_enable;
    next_count_end_int_enable  = count_end_int_enable;
    if (ctrl_wr.write) begin
      if (ctrl_wr.access_size != dmaie_pkg::DMAIE_SIZE_BAD_E) begin
        next_access_size = ctrl_wr.access_size;
      end
      if (ctrl_wr.xfer_mode != dmaie_pkg::DMAIE_MODE_BAD_E) begin
        next_xfer_mode = ctrl_wr.xfer_mode;
      end
      next_size_error_int_enable = ctrl_wr.size_error_int_enable;
      next_escape_int_enable     = ctrl_wr.escape_int_enable;
      next_count_end_int_enable  = ctrl_wr.count_end_int_enable;
    end
  end

  // Configuration registers.
  always_ff @(posedge clock) begin
    if (rst) begin
      access_size           <= `DMAIE_RST_FIELD;
      xfer_mode             <= `DMAIE_RST_FIELD;
      size_error_int_enable <= `DMAIE_RST_BIT;
      escape_int_enable     <= `DMAIE_RST_BIT;
      count_end_int_enable  <= `DMAIE_RST_BIT;
    end else begin
      access_size           <= next_access_size;
      xfer_mode             <= next_xfer_mode;
      size_error_int_enable <= next_size_error_int_enable;
      escape_int_enable     <= next_escape_int_enable;
      count_end_int_enable  <= next_count_end_int_enable;
    end
  end

  // Channel enable: software writes it, a size error knocks it down.
  // The hardware stop wins over a same-cycle software write.
  always_comb begin
    next_channel_enable = channel_enable;
    if (ctrl_wr.write) begin
      next_channel_enable = ctrl_wr.channel_enable;
    end
    if (size_err_hit) begin
      next_channel_enable = 1'h0;
    end
  end

  // Channel enable register.
  always_ff @(posedge clock) begin
    if (rst) begin
      channel_enable <= `DMAIE_RST_BIT;
    end else begin
      channel_enable <= next_channel_enable;
    end
  end

  // Flag update: setting events beat any clear in the same cycle so no event is lost.
  always_comb begin
    next_escape_flag    = escape_int_flag;
    next_count_end_flag = count_end_int_flag;
    if (ctrl_wr.write && ctrl_wr.channel_enable) begin
      next_escape_flag    = 1'h0;
      next_count_end_flag = 1'h0;
    end
    if (ctrl_wr.write && ctrl_wr.escape_flag_clear) begin
      next_escape_flag = 1'h0;
    end
    if (ctrl_wr.write && ctrl_wr.count_end_flag_clear) begin
      next_count_end_flag = 1'h0;
    end
    if (size_err_hit || escape_event) begin
      next_escape_flag = 1'h1;
    end
    if (last_xfer_done && (transfer_count == '0)) begin
      next_count_end_flag = 1'h1;
    end
  end

  // Flag registers.
  always_ff @(posedge clock) begin
    if (rst) begin
      escape_int_flag    <= `DMAIE_RST_BIT;
      count_end_int_flag <= `DMAIE_RST_BIT;
    end else begin
      escape_int_flag    <= next_escape_flag;
      count_end_int_flag <= next_count_end_flag;
    end
  end

  // Requests follow next-state values so they rise and drop with the flag and enable.
  always_ff @(posedge clock) begin
    if (rst) begin
      escape_int_req    <= 1'h0;
      count_end_int_req <= 1'h0;
      size_error        <= 1'h0;
    end else begin
      escape_int_req    <= next_escape_flag && next_escape_int_enable;
      count_end_int_req <= next_count_end_flag && next_count_end_int_enable;
      size_error        <= size_err_hit;
    end
  end

  // Readback register; the reserved bit is a constant zero and ignores writes.
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_rd <= '0;
    end else begin
      ctrl_rd.channel_enable        <= next_channel_enable;
      ctrl_rd.escape_int_flag       <= next_escape_flag;
      ctrl_rd.count_end_int_flag    <= next_count_end_flag;
      ctrl_rd.access_size           <= next_access_size;
      ctrl_rd.xfer_mode             <= next_xfer_mode;
      ctrl_rd.size_error_int_enable <= next_size_error_int_enable;
      ctrl_rd.reserved              <= `DMAIE_RST_BIT;
      ctrl_rd.escape_int_enable     <= next_escape_int_enable;
      ctrl_rd.count_end_int_enable  <= next_count_end_int_enable;
    end
  end

endmodule
`default_nettype wire

// File: core/dmaie_size_check.sv
// Combinational check: remaining count too small for the next request.
`timescale 1ns/1ps
`default_nettype none
`include "dmaie_regs.svh"

module dmaie_size_check #(
  parameter int COUNT_W = 16
) (
  input  wire logic [1:0]         access_size,
  input  wire logic [1:0]         xfer_mode,
  input  wire logic [COUNT_W-1:0] transfer_count,
  input  wire logic [COUNT_W-1:0] block_size,
  output logic                    too_small
);

  logic [COUNT_W-1:0] need;

  // Pick the amount moved per request from mode and access size.
  always_comb begin
    need = COUNT_W'(`DMAIE_BYTES_BYTE);
    case (access_size)
      `DMAIE_SIZE_WORD: need = COUNT_W'(`DMAIE_BYTES_WORD);
      `DMAIE_SIZE_LONG: need = COUNT_W'(`DMAIE_BYTES_LONG);
      default: need = COUNT_W'(`DMAIE_BYTES_BYTE);
    endcase
    if (xfer_mode == `DMAIE_MODE_BLOCK) begin
      need = block_size;
    end
    too_small = (transfer_count < need);
  end

endmodule
`default_nettype wire

// File: inc/dmaie_pkg.sv
// Types shared by the channel interrupt-enable block.
package dmaie_pkg;

  typedef enum logic [1:0] {
    DMAIE_SIZE_BYTE_E = 2'h0,
    DMAIE_SIZE_WORD_E = 2'h1,
    DMAIE_SIZE_LONG_E = 2'h2,
    DMAIE_SIZE_BAD_E  = 2'h3
  } dmaie_size_e;

  typedef enum logic [1:0] {
    DMAIE_MODE_NORMAL_E = 2'h0,
    DMAIE_MODE_BLOCK_E  = 2'h1,
    DMAIE_MODE_REPEAT_E = 2'h2,
    DMAIE_MODE_BAD_E    = 2'h3
  } dmaie_mode_e;

  // Software write of the control word: strobe plus data bits.
  typedef struct packed {
    logic        write;
    logic        channel_enable;
    logic        escape_flag_clear;
    logic        count_end_flag_clear;
    logic [1:0]  access_size;
    logic [1:0]  xfer_mode;
    logic        size_error_int_enable;
    logic        reserved;
    logic        escape_int_enable;
    logic        count_end_int_enable;
  } dmaie_ctrl_wr_s;

  // Control state read back by software.
  typedef struct packed {
    logic        channel_enable;
    logic        escape_int_flag;
    logic        count_end_int_flag;
    logic [1:0]  access_size;
    logic [1:0]  xfer_mode;
    logic        size_error_int_enable;
    logic        reserved;
    logic        escape_int_enable;
    logic        count_end_int_enable;
  } dmaie_ctrl_rd_s;

endpackage

// File: inc/dmaie_regs.svh
// Bit positions, encodings and reset values for the channel interrupt-enable block.
`ifndef DMAIE_REGS_SVH
`define DMAIE_REGS_SVH

// Control word bit positions (bits 17 down to 8 of the channel control register).
`define DMAIE_BIT_ESCAPE_FLAG     17
`define DMAIE_BIT_COUNT_END_FLAG  16
`define DMAIE_BIT_SIZE_HI         15
`define DMAIE_BIT_SIZE_LO         14
`define DMAIE_BIT_MODE_HI         13
`define DMAIE_BIT_MODE_LO         12
`define DMAIE_BIT_SIZE_ERR_IE     11
`define DMAIE_BIT_RESERVED        10
`define DMAIE_BIT_ESCAPE_IE       9
`define DMAIE_BIT_COUNT_END_IE    8

// Access size field codes.
`define DMAIE_SIZE_BYTE           2'h0
`define DMAIE_SIZE_WORD           2'h1
`define DMAIE_SIZE_LONG           2'h2

// Transfer mode field codes.
`define DMAIE_MODE_NORMAL         2'h0
`define DMAIE_MODE_BLOCK          2'h1
`define DMAIE_MODE_REPEAT         2'h2

// Bytes moved per request for each access size.
`define DMAIE_BYTES_BYTE          3'h1
`define DMAIE_BYTES_WORD          3'h2
`define DMAIE_BYTES_LONG          3'h4

// Reset values.
`define DMAIE_RST_BIT             1'h0
`define DMAIE_RST_FIELD           2'h0

`endif

// File: testbench/dmaie_channel_properties.sv
// Port-level checker for the channel interrupt-enable block.
`timescale 1ns/1ps
`default_nettype none
module dmaie_channel_properties #(
  parameter int COUNT_W = 16
) (
  input wire logic                      clock,
  input wire logic                      rst,
  input wire dmaie_pkg::dmaie_ctrl_wr_s ctrl_wr,
  input wire logic                      xfer_request,
  input wire logic                      last_xfer_done,
  input wire logic                      escape_event,
  input wire logic [COUNT_W-1:0]        transfer_count,
  input wire logic [COUNT_W-1:0]        block_size,
  input wire dmaie_pkg::dmaie_ctrl_rd_s ctrl_rd,
  input wire logic                      size_error,
  input wire logic                      escape_int_req,
  input wire logic                      count_end_int_req
);
  logic [COUNT_W-1:0] need;
  logic               err_now;
  // Bytes one request needs; a write in the same cycle is left out as its order is a choice.
  assign need = (ctrl_rd.xfer_mode == 2'h1) ? block_size : COUNT_W'(3'h1 << ctrl_rd.access_size);
  assign err_now = xfer_request && !ctrl_wr.write && ctrl_rd.channel_enable
    && ctrl_rd.size_error_int_enable && transfer_count < need;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_ERR_CAUSE: assert property (
    err_now |=> size_error && !ctrl_rd.channel_enable) else $error("size error missed");
  AST_ERR_FLAG: assert property (
    size_error |-> ctrl_rd.escape_int_flag) else $error("escape flag not set");
  AST_ERR_GATED: assert property (
    size_error |-> $past(ctrl_rd.size_error_int_enable)) else $error("size error while off");
  AST_RSV_ZERO: assert property (
    !ctrl_rd.reserved) else $error("reserved bit set");
  AST_ESC_REQ: assert property (
    escape_int_req == (ctrl_rd.escape_int_flag && ctrl_rd.escape_int_enable))
    else $error("escape request wrong");
  AST_END_REQ: assert property (
    count_end_int_req == (ctrl_rd.count_end_int_flag && ctrl_rd.count_end_int_enable))
    else $error("end request wrong");
  AST_RST_EN: assert property (
    $past(rst) |-> ctrl_rd[3:0] == 4'h0) else $error("enables not zero after reset");
  AST_EN_CLR: assert property (
    ctrl_wr.write && ctrl_wr.channel_enable && !xfer_request && !last_xfer_done && !escape_event
    |=> !ctrl_rd.escape_int_flag && !ctrl_rd.count_end_int_flag) else $error("flags kept");
  AST_CNT_END: assert property (
    last_xfer_done && transfer_count == '0 |=> ctrl_rd.count_end_int_flag)
    else $error("count end flag missed");
  // Main scenarios reached by the bench.
  cover property (size_error);
  cover property (escape_int_req);
  cover property (count_end_int_req);
endmodule
bind dmaie_channel dmaie_channel_properties #(.COUNT_W(COUNT_W)) u_props (.clock, .rst, .ctrl_wr,
  .xfer_request, .last_xfer_done, .escape_event, .transfer_count, .block_size, .ctrl_rd,
  .size_error, .escape_int_req, .count_end_int_req);
`default_nettype wire

// File: testbench/dmaie_int_sink.sv
// Interrupt controller stand-in that counts raised requests.
`timescale 1ns/1ps
`default_nettype none
module dmaie_int_sink (
  input  wire logic  clock,
  input  wire logic  rst,
  input  wire logic  req,
  output logic [7:0] seen
);
  logic last;
  // Counting rising edges exposes a request that flickers or repeats.
  always_ff @(posedge clock) begin
    last <= req;
    seen <= rst ? 8'h00 : seen + 8'(req && !last);
  end
endmodule
`default_nettype wire

// File: testbench/tb_dmaie_channel.sv
// Directed bench for the channel interrupt-enable block.
`timescale 1ns/1ps
`default_nettype none
module tb_dmaie_channel;
  logic                      clock = 1'b0;
  logic                      rst = 1'b1;
  dmaie_pkg::dmaie_ctrl_wr_s ctrl_wr = '0;
  logic [2:0]                pl = 3'h0;
  logic [15:0]               cnt = 16'h0000;
  logic [15:0]               blk = 16'h0008;
  dmaie_pkg::dmaie_ctrl_rd_s rd;
  logic                      serr;
  logic                      ereq;
  logic                      creq;
  logic [7:0]                seen;
  int                        err_count = 0;
  int                        n_tests = 0;
  logic [1:0]                szt [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
  logic [1:0]                mdt [8] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1};
  logic [15:0]               ct [8] = '{16'h0, 16'h1, 16'h1, 16'h2, 16'h3, 16'h4, 16'h7, 16'h8};
  dmaie_channel DUT (.clock(clock), .rst(rst), .ctrl_wr(ctrl_wr), .xfer_request(pl[2]),
    .last_xfer_done(pl[1]), .escape_event(pl[0]), .transfer_count(cnt), .block_size(blk),
    .ctrl_rd(rd), .size_error(serr), .escape_int_req(ereq), .count_end_int_req(creq));
  dmaie_int_sink u_sink (.clock(clock), .rst(rst), .req(creq), .seen(seen));
  always #5 clock = ~clock;
  task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write word is {enable, clears, size, mode, enables}; #1 lets the edge settle first.
  task automatic wr(input logic [10:0] w);
    @(posedge clock);
    ctrl_wr <= {1'b1, w};
    @(posedge clock);
    ctrl_wr <= '0;
    #1;
  endtask
  task automatic pulse(input logic [2:0] p, input logic [15:0] c);
    @(posedge clock);
    pl <= p;
    cnt <= c;
    @(posedge clock);
    pl <= 3'h0;
    #1;
  endtask
  task automatic summarize();
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // The tests take under 200 cycles, so 3000 means a hang.
  initial begin
    repeat (3000) @(posedge clock);
    err_count++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    #1;
    ck({serr, ereq, creq, rd}, 16'h0000);
    wr({1'h1, 2'h0, 2'h2, 2'h0, 4'hF});
    ck(rd, {1'h1, 2'h0, 2'h2, 2'h0, 4'hB});
    wr({1'h0, 2'h0, 2'h3, 2'h3, 4'hB});
    ck(rd, {1'h0, 2'h0, 2'h2, 2'h0, 4'hB});
    // Even entries fall one unit short of a request; rd[10] is the enable, rd[9] the flag.
    for (int i = 0; i < 8; i++) begin
      wr({1'h1, 2'h0, szt[i], mdt[i], 4'hB});
      pulse(3'h4, ct[i]);
      ck({serr, rd[10], rd[9], ereq}, {4{i % 2 == 0}} ^ 4'h4);
    end
    pulse(3'h4, 16'h0000);
    wr({1'h0, 2'h0, 2'h0, 2'h1, 4'h9});
    ck(ereq, 16'h0000);
    wr({1'h0, 2'h0, 2'h0, 2'h1, 4'hB});
    ck(ereq, 16'h0001);
    wr({1'h0, 2'h2, 2'h0, 2'h1, 4'hB});
    ck(ereq, 16'h0000);
    wr({1'h1, 2'h0, 2'h0, 2'h0, 4'h3});
    pulse(3'h4, 16'h0000);
    ck({serr, rd.channel_enable, ereq}, 16'h0002);
    pulse(3'h2, 16'h0005);
    ck(creq, 16'h0000);
    pulse(3'h2, 16'h0000);
    ck({rd.count_end_int_flag, creq}, 16'h0003);
    wr({1'h0, 2'h0, 2'h0, 2'h0, 4'h2});
    ck({rd.count_end_int_flag, creq}, 16'h0002);
    pulse(3'h1, 16'h0000);
    ck(ereq, 16'h0001);
    wr({1'h1, 2'h0, 2'h0, 2'h0, 4'h3});
    ck({rd.escape_int_flag, rd.count_end_int_flag, ereq, creq}, 16'h0000);
    ck(seen, 16'h0001);
    // A reset in mid-run must drop the enables that software left set.
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    ck({serr, ereq, creq, rd}, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
